//--- design/asp_core.sv
// The implementer's own choices: the register offsets and register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// R1 - Master drives bit clock and word select; slave takes them; data always out.
// R2 - I2S channel words are 16 bits, left word MSB on first data bit.
// R3 - I2S MSB goes out one bit clock after word select changes.
// R4 - Word select low carries left channel, high carries right channel.
// R5 - Output bits change on falling bit clock edges, captured on rising.
// R6 - I2S and PCM share one engine; only one personality active.
// R7 - PCM master makes bit clock and frame sync; slave takes them as inputs.
// R8 - Up to three full-duplex voice channels share the PCM line.
// R9 - Each frame holds at most 16 slots.
// R10 - Slot count and bit rate are selected by software.
// R11 - A channel transmits and receives in the same slot.
// R12 - Data output is released in slots that no channel uses.
// R13 - Release happens at the falling edge inside a used slot's last bit.
// R14 - Short sync is a one bit high pulse on the rising edge.
// R15 - Slave sees short sync on a fall; next rise starts slot zero.
// R16 - Long sync is three bits high, starting with slot zero's first bit.
// R17 - Narrowband mode uses 13 of 16 bits at a chosen place and order.
// R18 - Unused bits ignored on receive, filled as selected on transmit.
// R19 - Reset format is 13-bit left justified, MSB first.
// R20 - Burst mode runs the PCM bit clock up to 24 MHz.
// R21 - Burst starts only on a host command.
// R22 - The host sets mode, sync type and format.
// R23 - Received bits are captured on rising bit clock edges.

module asp_core (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Avalon-MM register slave
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Bit clock pin
  input wire logic bclk_i,
  output logic bclk_o,
  output logic bclk_oe,
  // Word select or frame sync pin
  input wire logic sync_i,
  output logic sync_o,
  output logic sync_oe,
  // Serial data pins
  input wire logic sdin_i,
  output logic sdout_o,
  output logic sdout_oe
);

  // ========================================================
  // Registers
  asp_pkg::asp_ctrl_type ctrl_r;
  asp_pkg::asp_fmt_type fmt_r;
  asp_pkg::asp_chan_type [2:0] chan_r;
  logic [15:0] tx_r [asp_pkg::NCHAN];
  logic [15:0] rx_r [asp_pkg::NCHAN];
  logic burst_r;
  logic [7:0] frames_r;
  logic wait_r;
  logic [31:0] rdata_r;
  logic [31:0] rd_nxt;
  logic [31:0] wmerged;
  logic acc_wr;

  function automatic logic [31:0] merge(input logic [31:0] o,
    input logic [31:0] n, input logic [3:0] be);
    logic [31:0] m;
    m = o;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        m[i*8 +: 8] = n[i*8 +: 8];
      end
    end
    return m;
  endfunction : merge

  // One wait state: the request is taken on the edge where wait is low.
  assign acc_wr = avs_write && !wait_r;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      wait_r <= 1'b1;
    end else begin
      wait_r <= !((avs_read || avs_write) && wait_r);
    end
  end

  always_comb begin
    rd_nxt = 32'h0000_0000;
    wmerged = merge(rd_nxt, avs_writedata, avs_byteenable);
    unique case (avs_address)
      asp_pkg::REG_CTRL: rd_nxt = 32'(ctrl_r);
      asp_pkg::REG_FMT: rd_nxt = 32'(fmt_r);
      asp_pkg::REG_SLOT: rd_nxt = 32'(chan_r);
      asp_pkg::REG_STAT: begin
        rd_nxt[asp_pkg::STAT_BURST] = burst_r;
        rd_nxt[asp_pkg::STAT_SYNC] = sync_o;
        rd_nxt[asp_pkg::STAT_FRAMES +: 8] = frames_r;
      end
      default: begin
        for (int c = 0; c < asp_pkg::NCHAN; c++) begin
          if (avs_address == asp_pkg::REG_TX0 + 6'(4 * c)) begin
            rd_nxt = 32'(tx_r[c]);
          end
          if (avs_address == asp_pkg::REG_RX0 + 6'(4 * c)) begin
            rd_nxt = 32'(rx_r[c]);
          end
        end
      end
    endcase
    wmerged = merge(rd_nxt, avs_writedata, avs_byteenable);
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      rdata_r <= 32'h0000_0000;
    end else if ((avs_read || avs_write) && wait_r) begin
      rdata_r <= rd_nxt;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      ctrl_r <= asp_pkg::CTRL_RST;
      fmt_r <= asp_pkg::FMT_RST; // [R19]
      chan_r <= asp_pkg::SLOT_RST;
      for (int c = 0; c < asp_pkg::NCHAN; c++) begin
        tx_r[c] <= 16'h0000;
      end
    end else if (acc_wr) begin
      unique case (avs_address)
        asp_pkg::REG_CTRL: ctrl_r <= wmerged[8:0]; // [R6] [R10] [R22]
        asp_pkg::REG_FMT: fmt_r <= wmerged[8:0]; // [R17]
        asp_pkg::REG_SLOT: chan_r <= wmerged[14:0]; // [R8]
        default: begin
          for (int c = 0; c < asp_pkg::NCHAN; c++) begin
            if (avs_address == asp_pkg::REG_TX0 + 6'(4 * c)) begin
              tx_r[c] <= wmerged[15:0];
            end
          end
        end
      endcase
    end
  end

  // Burst changes state only through the command register.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      burst_r <= 1'b0;
    end else if (acc_wr && avs_address == asp_pkg::REG_CMD &&
                 avs_byteenable[0]) begin
      if (avs_writedata[asp_pkg::CMD_BURST_ON]) begin
        burst_r <= 1'b1; // [R21]
      end else if (avs_writedata[asp_pkg::CMD_BURST_OFF]) begin
        burst_r <= 1'b0;
      end
    end
  end

  // ========================================================
  // Pin synchronisers and slave edge detection
  logic [2:0] bclk_sy;
  logic [1:0] sync_sy;
  logic [1:0] sd_sy;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      bclk_sy <= 3'h0;
      sync_sy <= 2'h0;
      sd_sy <= 2'h0;
    end else begin
      bclk_sy <= {bclk_sy[1:0], bclk_i};
      sync_sy <= {sync_sy[0], sync_i};
      sd_sy <= {sd_sy[0], sdin_i};
    end
  end

  // ========================================================
  // Master bit clock divider
  logic [8:0] div_r;
  logic [8:0] half;
  logic tick;
  logic run_m;
  logic rise_ev;
  logic fall_ev;

  always_comb begin
    unique case (ctrl_r.rate)
      asp_pkg::RATE_128K: half = asp_pkg::HALF_128K;
      asp_pkg::RATE_512K: half = asp_pkg::HALF_512K;
      default: half = asp_pkg::HALF_1024K;
    endcase
    if (burst_r && ctrl_r.pcm) begin
      half = asp_pkg::HALF_BURST; // [R20]
    end
  end

  assign run_m = ctrl_r.en && ctrl_r.master;
  assign tick = run_m && (div_r == half - 9'h001);
  assign rise_ev = ctrl_r.master ? (tick && !bclk_o)
                                 : (bclk_sy[1] && !bclk_sy[2]);
  assign fall_ev = ctrl_r.master ? (tick && bclk_o)
                                 : (!bclk_sy[1] && bclk_sy[2]);

  always_ff @(posedge mclk) begin
    if (sys_rst || !run_m || tick) begin
      div_r <= 9'h000;
    end else begin
      div_r <= div_r + 9'h001;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      bclk_o <= 1'b0;
      bclk_oe <= 1'b0;
      sync_oe <= 1'b0;
    end else begin
      bclk_oe <= run_m; // [R1] [R7]
      sync_oe <= run_m;
      if (!run_m) begin
        bclk_o <= 1'b0;
      end else if (tick) begin
        bclk_o <= !bclk_o;
      end
    end
  end

  // ========================================================
  // Frame position: cnt_r is the index of the bit now on the line
  logic [7:0] cnt_r;
  logic [7:0] last;
  logic [7:0] lidx;
  logic [7:0] lidx_p1;
  logic sync_prev_r;
  logic short_hit;

  assign last = ctrl_r.pcm ? 8'((9'h010 << ctrl_r.slots_log2) - 9'h001)
                           : asp_pkg::I2S_LAST; // [R9] [R10]
  assign short_hit = !ctrl_r.master && ctrl_r.pcm && !ctrl_r.long_sync &&
                     sync_sy[1];
  assign lidx = short_hit ? 8'h00 : (cnt_r == last ? 8'h00 : cnt_r + 8'h01);
  assign lidx_p1 = lidx + 8'h01;

  always_ff @(posedge mclk) begin
    if (sys_rst || !ctrl_r.en) begin
      cnt_r <= 8'h00;
      sync_prev_r <= 1'b0;
    end else if (fall_ev) begin
      cnt_r <= lidx; // [R15]
    end else if (rise_ev) begin
      sync_prev_r <= sync_sy[1];
      if (!ctrl_r.master && !ctrl_r.pcm && sync_sy[1] != sync_prev_r) begin
        cnt_r <= sync_sy[1] ? 8'h0F : 8'h1F; // [R3]
      end else if (!ctrl_r.master && ctrl_r.pcm && ctrl_r.long_sync &&
                   sync_sy[1] && !sync_prev_r) begin
        cnt_r <= 8'h00; // [R16]
      end
    end
  end

  // Master word select and frame sync.
  always_ff @(posedge mclk) begin
    if (sys_rst || !run_m) begin
      sync_o <= 1'b0;
    end else if (!ctrl_r.pcm && fall_ev) begin
      sync_o <= lidx_p1[4]; // [R3] [R4]
    end else if (ctrl_r.pcm && rise_ev) begin
      if (ctrl_r.long_sync) begin
        sync_o <= cnt_r < asp_pkg::LONG_SYNC_BITS; // [R16]
      end else begin
        sync_o <= cnt_r == last; // [R14]
      end
    end
  end

  // ========================================================
  // Slot decode and sample formatting
  typedef struct packed {
    logic hit;
    logic [1:0] ch;
  } asp_sel_type;

  function automatic asp_sel_type pick(input logic [7:0] idx,
    input logic pcm, input asp_pkg::asp_chan_type [2:0] ch);
    asp_sel_type s;
    s = '{hit: !pcm, ch: {1'b0, idx[4]}}; // [R4]
    if (pcm) begin
      for (int c = asp_pkg::NCHAN - 1; c >= 0; c--) begin
        if (ch[c].en && ch[c].slot == idx[7:4]) begin
          s = '{hit: 1'b1, ch: 2'(c)}; // [R11]
        end
      end
    end
    return s;
  endfunction : pick

  function automatic logic [15:0] fmt_tx(input logic [15:0] s,
    input asp_pkg::asp_fmt_type f);
    logic [2:0] fill;
    logic [18:0] ext;
    unique case (f.fill_mode)
      asp_pkg::FILL_ZERO: fill = 3'h0;
      asp_pkg::FILL_ONE: fill = 3'h7;
      asp_pkg::FILL_SIGN: fill = {3{s[12]}};
      asp_pkg::FILL_PROG: fill = f.fill_val;
    endcase
    ext = {fill, s[12:0], fill} >> f.shift;
    return f.narrow ? ext[15:0] : s; // [R17] [R18]
  endfunction : fmt_tx

  function automatic logic [15:0] fmt_rx(input logic [15:0] w,
    input asp_pkg::asp_fmt_type f);
    logic [15:0] al;
    al = w << f.shift;
    return f.narrow ? {{3{al[15]}}, al[15:3]} : w; // [R18]
  endfunction : fmt_rx

  asp_sel_type tsel;
  asp_sel_type rsel;
  logic [15:0] tword;
  logic [3:0] tbit;
  logic [3:0] rbit;
  logic [15:0] rword;
  logic [15:0] rsh_r;

  always_comb begin
    tsel = pick(lidx, ctrl_r.pcm, chan_r);
    rsel = pick(cnt_r, ctrl_r.pcm, chan_r);
    tword = ctrl_r.pcm ? fmt_tx(tx_r[tsel.ch], fmt_r) : tx_r[tsel.ch];
    tbit = (ctrl_r.pcm && fmt_r.lsb_first) ? lidx[3:0] : 4'hF - lidx[3:0];
    rbit = (ctrl_r.pcm && fmt_r.lsb_first) ? cnt_r[3:0] : 4'hF - cnt_r[3:0];
    rword = rsh_r;
    rword[rbit] = sd_sy[1];
  end

  // ========================================================
  // Serial output: launched on falling edges
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      sdout_o <= 1'b0;
      sdout_oe <= 1'b1;
    end else if (!ctrl_r.pcm) begin
      sdout_oe <= 1'b1; // [R1]
      if (ctrl_r.en && fall_ev) begin
        sdout_o <= tword[tbit]; // [R2] [R3] [R5]
      end
    end else if (!ctrl_r.en) begin
      sdout_oe <= 1'b0;
    end else if (fall_ev) begin
      sdout_oe <= tsel.hit; // [R12] [R13]
      sdout_o <= tsel.hit & tword[tbit]; // [R5]
    end
  end

  // ========================================================
  // Serial input: captured on rising edges
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      rsh_r <= 16'h0000;
      for (int c = 0; c < asp_pkg::NCHAN; c++) begin
        rx_r[c] <= 16'h0000;
      end
    end else if (ctrl_r.en && rise_ev && rsel.hit) begin
      rsh_r <= rword; // [R23]
      if (cnt_r[3:0] == 4'hF) begin
        rx_r[rsel.ch] <= ctrl_r.pcm ? fmt_rx(rword, fmt_r) : rword;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst || !ctrl_r.en) begin
      frames_r <= 8'h00;
    end else if (fall_ev && lidx == 8'h00) begin
      frames_r <= frames_r + 8'h01;
    end
  end

  assign avs_readdata = rdata_r;
  assign avs_waitrequest = wait_r;

  // ========================================================
  // Assertions
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  sequence s_req_held;
    (avs_read || avs_write) && wait_r;
  endsequence
  sequence s_ack;
    !wait_r ##1 wait_r;
  endsequence

  bus_one_wait_a: assert property (s_req_held |=> s_ack)
    else $error("register access not answered after one wait");
  i2s_dout_on_a: assert property (!ctrl_r.pcm && $past(!ctrl_r.pcm)
    |-> sdout_oe) // [R1]
    else $error("serial data not driven in i2s mode");
  master_pins_a: assert property (run_m ##1 run_m |-> bclk_oe && sync_oe) // [R1]
    else $error("master does not drive clock and sync");
  i2s_msb_a: assert property (ctrl_r.en && !ctrl_r.pcm && fall_ev &&
    lidx[3:0] == 4'h0 |=> sdout_o == $past(tword[15])) // [R3]
    else $error("i2s word does not start with its msb");
  sync_on_rise_a: assert property ($rose(sync_o) && ctrl_r.pcm
    |-> $rose(bclk_o)) // [R14]
    else $error("frame sync not aligned to rising clock");
  short_pos_a: assert property ($rose(sync_o) && ctrl_r.pcm &&
    !ctrl_r.long_sync |-> cnt_r == last) // [R14]
    else $error("short sync not in the bit before slot zero");
  long_pos_a: assert property ($rose(sync_o) && ctrl_r.pcm &&
    ctrl_r.long_sync |-> cnt_r == 8'h00) // [R16]
    else $error("long sync not starting with slot zero");
  slave_short_a: assert property (ctrl_r.en && short_hit && fall_ev
    |=> cnt_r == 8'h00) // [R15]
    else $error("short sync did not restart the frame");
  idle_slot_a: assert property (ctrl_r.en && ctrl_r.pcm && fall_ev &&
    !tsel.hit |=> !sdout_oe) // [R12]
    else $error("data driven in an unused slot");
  burst_cmd_a: assert property ($rose(burst_r) |-> $past(acc_wr) &&
    $past(avs_address) == asp_pkg::REG_CMD) // [R21]
    else $error("burst entered without a command");
  reset_fmt_a: assert property ($fell(sys_rst) |-> // [R19]
    fmt_r == asp_pkg::FMT_RST)
    else $error("format not default after reset");

endmodule : asp_core
`default_nettype wire

//--- inc/asp_pkg.sv
package asp_pkg;

  // ==========================================================
  // Register map, byte addresses on the Avalon-MM slave
  localparam logic [5:0] REG_CTRL = 6'h00;
  localparam logic [5:0] REG_FMT = 6'h04;
  localparam logic [5:0] REG_SLOT = 6'h08;
  localparam logic [5:0] REG_STAT = 6'h0C;
  localparam logic [5:0] REG_CMD = 6'h10;
  localparam logic [5:0] REG_TX0 = 6'h14;
  localparam logic [5:0] REG_RX0 = 6'h20;
  localparam int NCHAN = 3;

  // ==========================================================
  // Field layouts
  typedef enum logic [1:0] {
    RATE_128K = 2'b00,
    RATE_512K = 2'b01,
    RATE_1024K = 2'b10,
    RATE_1024K_ALT = 2'b11
  } asp_rate_type;

  typedef enum logic [1:0] {
    FILL_ZERO = 2'b00,
    FILL_ONE = 2'b01,
    FILL_SIGN = 2'b10,
    FILL_PROG = 2'b11
  } asp_fill_type;

  typedef struct packed {
    logic [2:0] slots_log2;
    asp_rate_type rate;
    logic long_sync;
    logic master;
    logic pcm;
    logic en;
  } asp_ctrl_type;

  typedef struct packed {
    logic [2:0] fill_val;
    asp_fill_type fill_mode;
    logic lsb_first;
    logic [1:0] shift;
    logic narrow;
  } asp_fmt_type;

  typedef struct packed {
    logic en;
    logic [3:0] slot;
  } asp_chan_type;

  localparam asp_ctrl_type CTRL_RST = 9'h000;
  localparam asp_fmt_type FMT_RST = 9'h001;
  localparam logic [14:0] SLOT_RST = 15'h0000;
  localparam int CMD_BURST_ON = 0;
  localparam int CMD_BURST_OFF = 1;
  localparam int STAT_BURST = 0;
  localparam int STAT_SYNC = 1;
  localparam int STAT_FRAMES = 8;

  // ==========================================================
  // Word and frame geometry
  localparam int WORD_BITS = 16;
  localparam int SAMPLE_BITS = 13;
  localparam logic [7:0] I2S_LAST = 8'h1F;
  localparam logic [7:0] LONG_SYNC_BITS = 8'h03;

  // ==========================================================
  // Bit clock timing in mclk cycles
  localparam int CLK_PERIOD_NS = 10;
  localparam int RATE_128K_HZ = 128000;
  localparam int RATE_512K_HZ = 512000;
  localparam int RATE_1024K_HZ = 1024000;
  localparam int BURST_MAX_HZ = 24000000;
  localparam int NS_PER_S = 1000000000;
  localparam logic [8:0] HALF_128K =
    9'(NS_PER_S / (2 * RATE_128K_HZ * CLK_PERIOD_NS));
  localparam logic [8:0] HALF_512K =
    9'(NS_PER_S / (2 * RATE_512K_HZ * CLK_PERIOD_NS));
  localparam logic [8:0] HALF_1024K =
    9'(NS_PER_S / (2 * RATE_1024K_HZ * CLK_PERIOD_NS));
  localparam logic [8:0] HALF_BURST =
    9'((NS_PER_S + 2 * BURST_MAX_HZ * CLK_PERIOD_NS - 1) /
       (2 * BURST_MAX_HZ * CLK_PERIOD_NS));

endpackage : asp_pkg

//--- verification/asp_codec_model.sv
`timescale 1ns/1ps
`default_nettype none
module asp_codec_model (
  // Model controls
  input wire logic run,
  input wire logic long_sync,
  input wire logic [31:0] frame_w,
  // Pins as seen on the wires
  input wire logic bclk,
  input wire logic sync,
  input wire logic sd,
  input wire logic sd_oe,
  output logic bclk_drv,
  output logic sync_drv,
  output logic sdin,
  // Bits taken at bit clock rises, newest in bit 0
  output logic [31:0] cap_sd,
  output logic [31:0] cap_ws,
  output logic [31:0] cap_oe
);
  logic [4:0] nxt_r;
  logic [4:0] ptr_r;
  logic ws_r;

  initial begin
    bclk_drv = 1'b0;
    sync_drv = 1'b0;
    sdin = 1'b0;
    nxt_r = 5'h00;
    ptr_r = 5'h00;
    ws_r = 1'b0;
  end

  // ==========================================================
  // Frame master: 32 bits a frame, clock stands low when idle.
  always begin
    #80;
    bclk_drv = run ? ~bclk_drv : 1'b0;
  end

  always @(posedge bclk_drv) begin
    nxt_r <= nxt_r + 5'h01;
    if (!long_sync) sync_drv <= (nxt_r == 5'h1F);
  end

  always @(negedge bclk_drv) begin
    if (long_sync) sync_drv <= (nxt_r < 5'h03);
  end

  // ==========================================================
  // Receiver samples on rises; sender launches on falls.
  always @(posedge bclk) begin
    cap_sd <= {cap_sd[30:0], sd};
    cap_ws <= {cap_ws[30:0], sync};
    cap_oe <= {cap_oe[30:0], sd_oe};
    ws_r <= sync;
    if (sync !== ws_r) ptr_r <= sync ? 5'h0F : 5'h1F;
  end

  always @(negedge bclk) begin
    sdin <= frame_w[ptr_r];
    ptr_r <= ptr_r - 5'h01;
  end
endmodule : asp_codec_model
`default_nettype wire

//--- verification/asp_core_bench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin \
  n_errors++; $display("mismatch at %0t got %h exp %h", $time, got, exp); \
  end end

module asp_core_bench;
  localparam logic [15:0] TXW = 16'h1A5B;
  logic mclk;
  logic sys_rst;
  logic [5:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [3:0] avs_byteenable;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic bclk_o, bclk_oe, sync_o, sync_oe, sdout_o, sdout_oe;
  logic m_run, m_long, m_bclk, m_sync, m_sdin;
  logic [31:0] m_frame, cap_sd, cap_ws, cap_oe, rd;
  wire logic bclk_w;
  wire logic sync_w;
  int n_errors;
  int checked;
  logic [2:0] fills [4];

  // A pin is driven by the core while its enable is up, otherwise by the model.
  assign bclk_w = bclk_oe ? bclk_o : m_bclk;
  assign sync_w = sync_oe ? sync_o : m_sync;

  initial mclk = 1'b0;
  always #5 mclk = ~mclk;

  asp_core dut_u (
    .mclk(mclk), .sys_rst(sys_rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .bclk_i(bclk_w), .bclk_o(bclk_o), .bclk_oe(bclk_oe),
    .sync_i(sync_w), .sync_o(sync_o), .sync_oe(sync_oe),
    .sdin_i(m_sdin), .sdout_o(sdout_o), .sdout_oe(sdout_oe)
  );

  asp_codec_model model_u (
    .run(m_run), .long_sync(m_long), .frame_w(m_frame),
    .bclk(bclk_w), .sync(sync_w), .sd(sdout_o), .sd_oe(sdout_oe),
    .bclk_drv(m_bclk), .sync_drv(m_sync), .sdin(m_sdin),
    .cap_sd(cap_sd), .cap_ws(cap_ws), .cap_oe(cap_oe)
  );

  // ==========================================================
  // Closing report
  task automatic test_done;
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : test_done

  // ==========================================================
  // Bus cycles and waits
  task automatic bus(input logic wr, input logic [5:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    avs_address <= a;
    avs_write <= wr;
    avs_read <= ~wr;
    avs_writedata <= d;
    do begin
      @(posedge mclk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 200);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (n >= 200) begin
      n_errors++;
      test_done();
    end
    @(posedge mclk);
  endtask : bus

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr

  // Sel 0 is the bit clock wire, 1 the sync wire, 2 the clock output.
  task automatic wait_for(input int sel, input logic lvl, output int cyc);
    logic v;
    cyc = 0;
    do begin
      @(posedge mclk);
      cyc++;
      v = (sel == 0) ? bclk_w : (sel == 1) ? sync_w : bclk_o;
    end while (v !== lvl && cyc < 20000);
    if (cyc >= 20000) begin
      n_errors++;
      test_done();
    end
  endtask : wait_for

  task automatic frames(input int n);
    int c;
    repeat (n) begin
      wait_for(1, 1'b0, c);
      wait_for(1, 1'b1, c);
    end
  endtask : frames

  // ==========================================================
  // Scenarios
  task automatic reg_reset;
    bus(1'b0, asp_pkg::REG_CTRL, 32'h0, rd);
    `CHK(rd, 32'h0000_0000)
    bus(1'b0, asp_pkg::REG_FMT, 32'h0, rd);
    `CHK(rd, {23'h0, asp_pkg::FMT_RST})
    bus(1'b0, asp_pkg::REG_SLOT, 32'h0, rd);
    `CHK(rd, 32'h0000_0000)
    bus(1'b0, 6'h3C, 32'h0, rd);
    `CHK(rd, 32'h0000_0000)
    bus(1'b0, asp_pkg::REG_STAT, 32'h0, rd);
    `CHK(rd[0], 1'b0)
  endtask : reg_reset

  task automatic i2s_master;
    int c;
    m_frame = 32'h1234_FEDC;
    wr(asp_pkg::REG_FMT, 32'h0);
    wr(asp_pkg::REG_TX0, 32'hA5C3);
    wr(asp_pkg::REG_TX0 + 6'h04, 32'h3C5A);
    wr(asp_pkg::REG_CTRL, 32'h025);
    frames(3);
    wait_for(1, 1'b0, c);
    wait_for(0, 1'b0, c);
    wait_for(0, 1'b1, c);
    repeat (2) @(posedge mclk);
    `CHK(cap_sd, 32'hA5C3_3C5A)
    `CHK(cap_ws, 32'h0001_FFFE)
    `CHK({bclk_oe, sync_oe, sdout_oe}, 3'b111)
    bus(1'b0, asp_pkg::REG_RX0, 32'h0, rd);
    `CHK(rd, 32'h0000_1234)
    bus(1'b0, asp_pkg::REG_RX0 + 6'h04, 32'h0, rd);
    `CHK(rd, 32'h0000_FEDC)
    wr(asp_pkg::REG_CTRL, 32'h0);
  endtask : i2s_master

  // Slave PCM, two slots of 16 bits; channel 0 in the given slot.
  task automatic pcm_slave(input logic lng, input logic slot,
                           input logic [8:0] fmt, input logic [15:0] exp);
    int c;
    m_long = lng;
    m_run = 1'b1;
    wr(asp_pkg::REG_FMT, {23'h0, fmt});
    wr(asp_pkg::REG_SLOT, {27'h0, 1'b1, 3'b000, slot});
    wr(asp_pkg::REG_TX0, {16'h0, TXW});
    wr(asp_pkg::REG_CTRL, lng ? 32'h04B : 32'h043);
    frames(3);
    repeat (2) @(posedge mclk);
    `CHK(cap_oe, slot ? 32'h0000_FFFF : 32'hFFFF_0000)
    `CHK(slot ? cap_sd[15:0] : cap_sd[31:16], exp)
    `CHK({bclk_oe, sync_oe}, 2'b00)
    if (slot) begin
      wait_for(0, 1'b0, c);
      repeat (6) @(posedge mclk);
      `CHK(sdout_oe, 1'b0)
    end
    wr(asp_pkg::REG_CTRL, 32'h0);
  endtask : pcm_slave

  task automatic burst;
    int c1;
    int c2;
    wr(asp_pkg::REG_CTRL, 32'h047);
    wr(asp_pkg::REG_CMD, 32'h1);
    bus(1'b0, asp_pkg::REG_STAT, 32'h0, rd);
    `CHK(rd[0], 1'b1)
    wait_for(2, 1'b0, c1);
    wait_for(2, 1'b1, c1);
    wait_for(2, 1'b0, c1);
    wait_for(2, 1'b1, c2);
    `CHK(c1 + c2, 2 * int'(asp_pkg::HALF_BURST))
    // Master short sync framing: channel 0 still owns slot 1.
    frames(3);
    repeat (2) @(posedge mclk);
    `CHK(cap_oe, 32'h0000_FFFF)
    `CHK(cap_sd[15:0], {TXW[12:0], 3'b101})
    `CHK({bclk_oe, sync_oe}, 2'b11)
    wr(asp_pkg::REG_CMD, 32'h2);
    bus(1'b0, asp_pkg::REG_STAT, 32'h0, rd);
    `CHK(rd[0], 1'b0)
    bus(1'b0, asp_pkg::REG_CMD, 32'h0, rd);
    `CHK(rd, 32'h0000_0000)
    wr(asp_pkg::REG_CTRL, 32'h0);
  endtask : burst

  // ==========================================================
  // Main sequence
  initial begin
    sys_rst = 1'b1;
    avs_address = 6'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_byteenable = 4'hF;
    avs_writedata = 32'h0;
    m_run = 1'b0;
    m_long = 1'b0;
    m_frame = 32'h0;
    n_errors = 0;
    checked = 0;
    fills = '{3'b000, 3'b111, {3{TXW[12]}}, 3'b101};
    repeat (6) @(posedge mclk);
    sys_rst <= 1'b0;
    @(posedge mclk);
    reg_reset();
    i2s_master();
    pcm_slave(1'b0, 1'b1, 9'h000, TXW);
    pcm_slave(1'b1, 1'b0, asp_pkg::FMT_RST, {TXW[12:0], 3'b000});
    for (int f = 0; f < 4; f++) begin
      pcm_slave(1'b0, 1'b1, {3'h5, 2'(f), 4'h1}, {TXW[12:0], fills[f]});
    end
    m_run = 1'b0;
    burst();
    test_done();
  end
endmodule : asp_core_bench
`default_nettype wire
